// ### hw/power_supervisor_watchdog.sv
// Supply supervisor: reset generator, three-level watchdog, power-fail warning
// and battery switchover select. Comparator levels are digital pin inputs.
`timescale 1ns/1ps
`default_nettype none
module power_supervisor_watchdog (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Service input, resolved by the pad into driven flag and level.
   input wire supervisor_pkg::service_pin_t watchdog_service_input_i,
   // Comparator results.
   input wire supervisor_pkg::compare_t compare_i,
   // Outputs to the processor and the supply switch.
   output logic reset_n_o,
   output logic reset_o,
   output logic power_fail_warning_output_o,
   output logic switched_supply_sel_batt_o
);
   // ======================================================================
   // Synchronised inputs.
   logic [5:0] raw;
   logic [5:0] syn;
   logic svc_driven;
   logic svc_level;
   logic supply_ok;
   logic main_above_batt;
   logic sense_ok;
   logic above_1v;

   // Pins all come from outside the clock domain.
   // Each level is synchronised on its own; they are slow, so a one-cycle skew is harmless.
   assign raw = {watchdog_service_input_i, compare_i};
   assign {svc_driven, svc_level, supply_ok, main_above_batt, sense_ok, above_1v} = syn;

   sync_stage #(.W(6)) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i(raw),
      .q_o(syn)
   );

   // ======================================================================
   // Supply switchover.
   logic backup;

   // Battery only when main is under threshold and under battery.
   assign backup = !supply_ok && !main_above_batt;

   // Selection comes from a flop as a data output.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         switched_supply_sel_batt_o <= 1'b0;
      end else begin
         switched_supply_sel_batt_o <= backup;
      end
   end

   // ======================================================================
   // Power-fail warning, off in backup to save battery.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         power_fail_warning_output_o <= 1'b0;
      end else begin
         power_fail_warning_output_o <= sense_ok && !backup;
      end
   end

   // ======================================================================
   // Watchdog.
   logic [supervisor_pkg::CNT_W-1:0] wd_cnt_q;
   logic prev_level_q;
   logic wd_active;
   logic toggle;
   logic wd_expire;
   logic reset_asserted;

   // Float, backup or an active reset stop the watchdog.
   // The pad turns the biased middle level of a floating pin into driven = 0.
   assign wd_active = svc_driven && !backup && !reset_asserted;
   // A 50 ns pulse survives sampling at 40 ns as at least one changed sample.
   assign toggle = svc_level != prev_level_q;
   assign wd_expire = wd_active &&
      (wd_cnt_q == supervisor_pkg::CNT_W'(supervisor_pkg::WATCHDOG_CYCLES - 1));

   // Level history follows the pin even while the timer is held.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prev_level_q <= 1'b0;
      end else begin
         prev_level_q <= svc_level;
      end
   end

   // Timer counts only while active; any toggle clears it.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wd_cnt_q <= '0;
      end else if (!wd_active || toggle || wd_expire) begin
         wd_cnt_q <= '0;
      end else begin
         wd_cnt_q <= wd_cnt_q + 1'b1;
      end
   end

   // ======================================================================
   // Reset generator.
   supervisor_pkg::rst_state_t state_q;
   logic [supervisor_pkg::CNT_W-1:0] rst_cnt_q;

   assign reset_asserted = (state_q != supervisor_pkg::RST_IDLE);

   // Hold while supply is low; then time one full pulse.
   // A dip in mid-pulse drops back to HOLD, so the pulse after it is full length.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_q <= supervisor_pkg::RST_HOLD;
         rst_cnt_q <= '0;
      end else begin
         case (state_q)
            supervisor_pkg::RST_HOLD: begin
               rst_cnt_q <= '0;
               if (supply_ok) begin
                  state_q <= supervisor_pkg::RST_PULSE;
               end
            end
            supervisor_pkg::RST_PULSE: begin
               if (!supply_ok) begin
                  state_q <= supervisor_pkg::RST_HOLD;
                  rst_cnt_q <= '0;
               end else if (rst_cnt_q ==
                  supervisor_pkg::CNT_W'(supervisor_pkg::RESET_CYCLES - 1)) begin
                  state_q <= supervisor_pkg::RST_IDLE;
                  rst_cnt_q <= '0;
               end else begin
                  rst_cnt_q <= rst_cnt_q + 1'b1;
               end
            end
            supervisor_pkg::RST_IDLE: begin
               rst_cnt_q <= '0;
               if (!supply_ok) begin
                  state_q <= supervisor_pkg::RST_HOLD;
               end else if (wd_expire) begin
                  state_q <= supervisor_pkg::RST_PULSE;
               end
            end
            default: begin
               state_q <= supervisor_pkg::RST_HOLD;
               rst_cnt_q <= '0;
            end
         endcase
      end
   end

   // Outputs are flopped; the pair is updated together so it never disagrees.
   // Below 1 V the pin is undefined; we simply keep asserting.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         reset_n_o <= 1'b0;
         reset_o <= 1'b1;
      end else begin
         reset_n_o <= !(reset_asserted || backup || !above_1v);
         reset_o <= reset_asserted || backup || !above_1v;
      end
   end

   // ======================================================================
   // Checks.
   property p_inverse;
      @(posedge clk_i) disable iff (!nrst_i) reset_o == !reset_n_o;
   endproperty
   a_inverse: assert property (p_inverse) else $error("reset pair disagrees");

   property p_backup_pf;
      @(posedge clk_i) disable iff (!nrst_i) backup |=> !power_fail_warning_output_o;
   endproperty
   a_backup_pf: assert property (p_backup_pf) else $error("warning high in backup");

   property p_backup_rst;
      @(posedge clk_i) disable iff (!nrst_i) backup |=> !reset_n_o;
   endproperty
   a_backup_rst: assert property (p_backup_rst) else $error("reset released in backup");

   property p_low_supply;
      @(posedge clk_i) disable iff (!nrst_i) !supply_ok |=> ##1 !reset_n_o;
   endproperty
   a_low_supply: assert property (p_low_supply) else $error("no reset on low supply");

   property p_pf_follow;
      @(posedge clk_i) disable iff (!nrst_i) (sense_ok && !backup) |=> power_fail_warning_output_o;
   endproperty
   a_pf_follow: assert property (p_pf_follow) else $error("warning not high");

   property p_float;
      @(posedge clk_i) disable iff (!nrst_i) !svc_driven |=> wd_cnt_q == '0;
   endproperty
   a_float: assert property (p_float) else $error("timer counts while floating");

   property p_held;
      @(posedge clk_i) disable iff (!nrst_i) reset_asserted |=> wd_cnt_q == '0;
   endproperty
   a_held: assert property (p_held) else $error("timer counts during reset");

   property p_toggle;
      @(posedge clk_i) disable iff (!nrst_i) toggle |=> wd_cnt_q == '0;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not clear timer");

   property p_expire;
      @(posedge clk_i) disable iff (!nrst_i)
         (wd_expire && supply_ok) |=> (state_q == supervisor_pkg::RST_PULSE) ##1 !reset_n_o;
   endproperty
   a_expire: assert property (p_expire) else $error("timeout gave no reset");

   property p_main;
      @(posedge clk_i) disable iff (!nrst_i) supply_ok |=> !switched_supply_sel_batt_o;
   endproperty
   a_main: assert property (p_main) else $error("battery chosen above threshold");

   property p_count;
      @(posedge clk_i) disable iff (!nrst_i)
         (wd_active && !toggle && !wd_expire) |=> wd_cnt_q == $past(wd_cnt_q) + 1'b1;
   endproperty
   a_count: assert property (p_count) else $error("timer did not advance");

   // ======================================================================
   // Assertion helper: cycles the active-low reset has been held low.
   // It watches the output pin itself, so a wrong pulse count in the
   // generator cannot hide behind the generator's own counter.
   logic [supervisor_pkg::CNT_W-1:0] low_cnt_q;

   // Saturates so that a long supply outage cannot wrap it back to zero.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         low_cnt_q <= '0;
      end else if (reset_n_o) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != '1) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   // ======================================================================
   // Checks on the reset generator, the supply select, the warning and the watchdog timer.
   property p_rst_len;
      @(posedge clk_i) disable iff (!nrst_i)
         $rose(reset_n_o) |-> low_cnt_q >= supervisor_pkg::CNT_W'(supervisor_pkg::RESET_CYCLES);
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset released too early");

   property p_hold_exit;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_HOLD && supply_ok) |=> (state_q == supervisor_pkg::RST_PULSE) && (rst_cnt_q == '0);
   endproperty
   a_hold_exit: assert property (p_hold_exit) else $error("no pulse after supply recovered");

   property p_hold_stay;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_HOLD && !supply_ok) |=> state_q == supervisor_pkg::RST_HOLD;
   endproperty
   a_hold_stay: assert property (p_hold_stay) else $error("hold left while supply low");

   property p_idle_low;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_IDLE && !supply_ok) |=> state_q == supervisor_pkg::RST_HOLD;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("low supply missed when idle");

   property p_brownout;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_PULSE && !supply_ok) |=> (state_q == supervisor_pkg::RST_HOLD) && (rst_cnt_q == '0);
   endproperty
   a_brownout: assert property (p_brownout) else $error("brownout did not restart pulse");

   property p_pulse_step;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_PULSE && supply_ok &&
          rst_cnt_q != supervisor_pkg::CNT_W'(supervisor_pkg::RESET_CYCLES - 1))
         |=> (state_q == supervisor_pkg::RST_PULSE) && (rst_cnt_q == $past(rst_cnt_q) + 1'b1);
   endproperty
   a_pulse_step: assert property (p_pulse_step) else $error("pulse timer did not advance");

   property p_pulse_end;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_PULSE && supply_ok &&
          rst_cnt_q == supervisor_pkg::CNT_W'(supervisor_pkg::RESET_CYCLES - 1))
         |=> state_q == supervisor_pkg::RST_IDLE;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

   property p_release;
      @(posedge clk_i) disable iff (!nrst_i)
         (state_q == supervisor_pkg::RST_IDLE && above_1v && !backup) |=> reset_n_o && !reset_o;
   endproperty
   a_release: assert property (p_release) else $error("reset not released when idle");

   property p_rel_supply;
      @(posedge clk_i) disable iff (!nrst_i)
         reset_n_o |-> $past(supply_ok, 2);
   endproperty
   a_rel_supply: assert property (p_rel_supply) else $error("reset released on low supply");

   property p_rel_1v;
      @(posedge clk_i) disable iff (!nrst_i)
         reset_n_o |-> $past(above_1v);
   endproperty
   a_rel_1v: assert property (p_rel_1v) else $error("reset released below floor");

   property p_rel_backup;
      @(posedge clk_i) disable iff (!nrst_i)
         reset_n_o |-> !$past(backup);
   endproperty
   a_rel_backup: assert property (p_rel_backup) else $error("reset released in backup");

   property p_low_1v;
      @(posedge clk_i) disable iff (!nrst_i)
         !above_1v |=> !reset_n_o && reset_o;
   endproperty
   a_low_1v: assert property (p_low_1v) else $error("reset not held below floor");

   property p_pf_low;
      @(posedge clk_i) disable iff (!nrst_i)
         !sense_ok |=> !power_fail_warning_output_o;
   endproperty
   a_pf_low: assert property (p_pf_low) else $error("warning high with sense low");

   property p_battery;
      @(posedge clk_i) disable iff (!nrst_i)
         backup |=> switched_supply_sel_batt_o;
   endproperty
   a_battery: assert property (p_battery) else $error("battery not chosen in backup");

   property p_main_low;
      @(posedge clk_i) disable iff (!nrst_i)
         (!supply_ok && main_above_batt) |=> !switched_supply_sel_batt_o;
   endproperty
   a_main_low: assert property (p_main_low) else $error("battery chosen below main");

   property p_backup_wd;
      @(posedge clk_i) disable iff (!nrst_i)
         backup |=> wd_cnt_q == '0;
   endproperty
   a_backup_wd: assert property (p_backup_wd) else $error("timer counts in backup");

   property p_restart;
      @(posedge clk_i) disable iff (!nrst_i)
         $rose(wd_active) |-> wd_cnt_q == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("timer did not restart from zero");

endmodule : power_supervisor_watchdog
`default_nettype wire

// ### hw/sync_stage.sv
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes the inputs are slow levels; no bus coherence is needed.
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Data.
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : sync_stage
`default_nettype wire

// ### inc/supervisor_pkg.sv
// Constants, state type and pin bundles for the supply supervisor block.
// Assumes a 25 MHz system clock; all comparator levels arrive as digital inputs.
// What this block does
// - Steady service input for timeout starts reset.
// - Floating service input disables watchdog entirely.
// - Reset or float holds watchdog timer cleared.
// - Watchdog restarts from zero once both released.
// - Any 50 ns pulse services the watchdog.
// - Watchdog timeout gives one 200 ms reset.
// - Reset on low supply or watchdog timeout.
// - Reset stays 200 ms after supply recovers.
// - Brownout during pulse restarts full 200 ms.
// - Reset held down to the 1 V floor.
// - Active-high reset is inverse of active-low.
// - Warning low when sense below reference.
// - Backup mode forces warning low.
// - Above threshold, output always from main supply.
// - Battery only when below threshold and battery.
// - Switchover uses the hysteresis comparator result.
// - Backup mode: watchdog off, reset asserted.
// - Floating service input reads as neither level.
package supervisor_pkg;

   // ======================================================================
   // Timing.
   localparam longint unsigned CLK_HZ = 64'd25_000_000;
   localparam longint unsigned WATCHDOG_TIMEOUT_MS = 64'd1600;
   localparam longint unsigned RESET_PULSE_WIDTH_MS = 64'd200;
   localparam int unsigned SERVICE_PULSE_NS = 50;
   localparam longint unsigned WATCHDOG_CYCLES = WATCHDOG_TIMEOUT_MS * CLK_HZ / 64'd1000;
   localparam longint unsigned RESET_CYCLES = RESET_PULSE_WIDTH_MS * CLK_HZ / 64'd1000;
   // Service pulse is shorter than one 40 ns cycle times two, so one sampled cycle counts.
   localparam int unsigned SERVICE_CYCLES = (SERVICE_PULSE_NS * 25 + 999) / 1000;
   localparam int unsigned CNT_W = 27;

   // ======================================================================
   // Reset generator state.
   typedef enum logic [1:0] {
      RST_HOLD,
      RST_PULSE,
      RST_IDLE
   } rst_state_t;

   // Three-level service input, already resolved by the pad.
   typedef struct packed {
      logic driven;
      logic level;
   } service_pin_t;

   // Comparator results, hysteresis applied outside.
   typedef struct packed {
      logic supply_ok;
      logic main_above_batt;
      logic sense_above_ref;
      logic supply_above_1v;
   } compare_t;

endpackage : supervisor_pkg

// ### sim/cpu_model.sv
// Processor model on the far side: services the watchdog input.
// Assumes the bench enables it only while service pulses are wanted.
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
   parameter int PERIOD = 100
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control from the bench.
   input wire logic en_i,
   // Pin towards the block.
   output supervisor_pkg::service_pin_t svc_o
);
   // ======================================================================
   // Service toggle.
   int cnt;
   // Toggles well inside the timeout; a released pin shows a changing level.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt <= 0;
         svc_o <= 2'b0_0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         svc_o.driven <= en_i;
         if (!en_i || cnt == PERIOD - 1) begin
            svc_o.level <= ~svc_o.level;
         end
      end
   end
endmodule : cpu_model
`default_nettype wire

// ### sim/power_supervisor_watchdog_tb.sv
// Self-checking bench for the supply supervisor.
// Assumes the package counts; the 200 ms hold is only checked as still held.
`timescale 1ns/1ps
`default_nettype none
module power_supervisor_watchdog_tb;
   // ======================================================================
   // Signals.
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic en = 1'b0;
   supervisor_pkg::service_pin_t svc;
   supervisor_pkg::compare_t cmp = 4'h0;
   logic reset_n_o;
   logic reset_o;
   logic warn;
   logic sel;
   int err_count = 0;
   int compares = 0;

   // Clock at 25 MHz.
   always #20 clk_i = ~clk_i;

   power_supervisor_watchdog uut (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .watchdog_service_input_i(svc),
      .compare_i(cmp),
      .reset_n_o(reset_n_o),
      .reset_o(reset_o),
      .power_fail_warning_output_o(warn),
      .switched_supply_sel_batt_o(sel)
   );

   cpu_model cpu (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .svc_o(svc));

   // ======================================================================
   // Helpers.
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Comparator levels change at an edge; the synchroniser needs 2 edges, the output flop one more.
   task automatic set_cmp(input logic [3:0] v);
      @(posedge clk_i);
      cmp <= v;
      repeat (6) @(posedge clk_i);
      // Look half a cycle later, where the flopped outputs have settled.
      @(negedge clk_i);
   endtask : set_cmp

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   // ======================================================================
   // Scenarios.
   task automatic t_power_up();
      set_cmp(4'b0111);
      chk(reset_n_o, 1'b0);
      chk(reset_o, 1'b1);
      set_cmp(4'b1111);
      repeat (1000) @(negedge clk_i);
      chk(reset_n_o, 1'b0);
      chk(reset_o, 1'b1);
      set_cmp(4'b0110);
      chk(reset_n_o, 1'b0);
      $display("test power_up done");
   endtask : t_power_up

   task automatic t_warning();
      set_cmp(4'b1101);
      chk(warn, 1'b0);
      chk(sel, 1'b0);
      set_cmp(4'b1011);
      chk(warn, 1'b1);
      chk(sel, 1'b0);
      $display("test warning done");
   endtask : t_warning

   task automatic t_backup();
      // Release the service pin first; a floating input must not matter.
      @(posedge clk_i);
      en <= 1'b0;
      set_cmp(4'b0011);
      chk(sel, 1'b1);
      chk(warn, 1'b0);
      chk(reset_n_o, 1'b0);
      chk(reset_o, 1'b1);
      set_cmp(4'b0111);
      chk(sel, 1'b0);
      chk(warn, 1'b1);
      chk(reset_n_o, 1'b0);
      $display("test backup done");
   endtask : t_backup

   // Mid-run block reset: all four outputs take their reset values.
   task automatic t_block_reset();
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk(reset_n_o, 1'b0);
      chk(reset_o, 1'b1);
      chk(warn, 1'b0);
      chk(sel, 1'b0);
      @(posedge clk_i);
      nrst_i <= 1'b1;
      set_cmp(4'b1011);
      chk(sel, 1'b0);
      chk(warn, 1'b1);
      chk(reset_n_o, 1'b0);
      $display("test block_reset done");
   endtask : t_block_reset

   // ======================================================================
   // Main sequence and watchdog.
   initial begin
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      en <= 1'b1;
      t_power_up();
      t_warning();
      t_backup();
      t_block_reset();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      end_of_test();
   end
endmodule : power_supervisor_watchdog_tb
`default_nettype wire
